// File: design/client_lane_end.sv
// Function
// - pass-through: eight preamble octets lead frame
// - preamble reversed: start 199:192, delimiter 255:248
// - addresses follow preamble in usual order
// - address bit 40 marks multicast
// - address bit 41 marks local administration
// - receive side forwards header and payload
// - received frame: DA, SA, type, payload, pad, CRC
// - top byte lane carries earliest octet
// - first address octet in top address lane
`timescale 1ns/1ps
`default_nettype none
module client_lane_end
	import frame_lane_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	frame_lane_if.client lane,
	input wire logic passthrough_i,
	input wire logic [PRE_W-1:0] preamble_i,
	input wire logic [ADDR_W-1:0] da_i,
	input wire logic [ADDR_W-1:0] sa_i,
	input wire logic [TL_W-1:0] tl_i,
	input wire logic hdr_valid_i,
	output logic hdr_ready_o,
	input wire logic [BUS_W-1:0] pay_data_i,
	input wire logic pay_last_i,
	input wire logic [UNUSED_W-1:0] pay_unused_i,
	input wire logic pay_valid_i,
	output logic pay_ready_o,
	output logic [BUS_W-1:0] rx_data_o,
	output logic rx_first_o,
	output logic rx_last_o,
	output logic [UNUSED_W-1:0] rx_unused_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i,
	output logic rx_multicast_o,
	output logic rx_local_o
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_BODY,
		ST_TAIL
	} state_t;

	state_t state;
	state_t next_state;
	logic [BUS_W-1:0] carry;
	logic [BUS_W-1:0] next_carry;
	logic [5:0] hdr_bytes;
	logic first_pending;
	logic [UNUSED_W-1:0] tail_unused;
	logic [UNUSED_W-1:0] next_tail_unused;
	logic [BUS_W-1:0] hdr_image;
	logic [2*BUS_W-1:0] merged;
	logic [6:0] total_bytes;
	logic hdr_fire;
	logic pay_fire;
	logic tx_fire;
	logic slot_free;
	logic load_beat;
	beat_t next_beat;
	logic next_tx_valid;
	logic rx_load;
	logic [ADDR_W-1:0] rx_da;

	// header image, left aligned, preamble octets in reversed lane order
	always_comb begin
		if (passthrough_i) begin
			hdr_image = {preamble_i, da_i, sa_i, tl_i, 80'h0};
		end else begin
			hdr_image = {da_i, sa_i, tl_i, 144'h0};
		end
	end

	assign hdr_fire = hdr_valid_i && hdr_ready_o;
	assign pay_fire = pay_valid_i && pay_ready_o;
	assign tx_fire = lane.tx_client_valid && lane.tx_client_ready;
	assign slot_free = !lane.tx_client_valid || lane.tx_client_ready;

	// payload slides down behind the octets still held back
	assign merged = {carry, 256'h0} | ({pay_data_i, 256'h0} >> {hdr_bytes, 3'b000});
	assign total_bytes = 7'({1'b0, hdr_bytes} + used_bytes(pay_unused_i));

	always_comb begin
		next_state = state;
		next_carry = carry;
		next_tail_unused = tail_unused;
		load_beat = 1'b0;
		next_beat = '{data: '0, first: 1'b0, last: 1'b0, unused: '0};
		case (state)
			ST_IDLE: begin
				if (hdr_fire) begin
					next_carry = hdr_image;
					next_state = ST_BODY;
				end
			end
			ST_BODY: begin
				if (pay_fire) begin
					load_beat = 1'b1;
					next_carry = merged[BUS_W-1:0];
					next_beat.data = merged[2*BUS_W-1:BUS_W];
					next_beat.first = first_pending;
					if (pay_last_i) begin
						if (total_bytes <= 7'(BUS_BYTES)) begin
							next_beat.last = 1'b1;
							next_beat.unused = UNUSED_W'(7'(BUS_BYTES) - total_bytes);
							next_state = ST_IDLE;
						end else begin
							next_tail_unused = UNUSED_W'(7'(2*BUS_BYTES) - total_bytes);
							next_state = ST_TAIL;
						end
					end
				end
			end
			ST_TAIL: begin
				if (slot_free) begin
					load_beat = 1'b1;
					next_beat.data = carry;
					next_beat.last = 1'b1;
					next_beat.unused = tail_unused;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	assign next_tx_valid = load_beat || (lane.tx_client_valid && !tx_fire);

	// frame sequencing
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= ST_IDLE;
			carry <= '0;
			tail_unused <= '0;
		end else begin
			state <= next_state;
			carry <= next_carry;
			tail_unused <= next_tail_unused;
		end
	end

	// header length of the frame in progress
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hdr_bytes <= 6'(HDR_BYTES_PLAIN);
			first_pending <= 1'b0;
		end else if (hdr_fire) begin
			hdr_bytes <= passthrough_i ? 6'(HDR_BYTES_PT) : 6'(HDR_BYTES_PLAIN);
			first_pending <= 1'b1;
		end else if (load_beat) begin
			first_pending <= 1'b0;
		end
	end

	// user side handshakes, one beat in flight
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hdr_ready_o <= 1'b0;
			pay_ready_o <= 1'b0;
		end else begin
			hdr_ready_o <= next_state == ST_IDLE && !hdr_fire;
			pay_ready_o <= next_state == ST_BODY && !next_tx_valid;
		end
	end

	// transmit beat toward the mac
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lane.tx_client_data_bus <= '0;
			lane.tx_client_first_beat <= 1'b0;
			lane.tx_client_last_beat <= 1'b0;
			lane.tx_client_unused_byte_count <= '0;
			lane.tx_client_valid <= 1'b0;
		end else begin
			lane.tx_client_valid <= next_tx_valid;
			if (load_beat) begin
				lane.tx_client_data_bus <= next_beat.data;
				lane.tx_client_first_beat <= next_beat.first;
				lane.tx_client_last_beat <= next_beat.last;
				lane.tx_client_unused_byte_count <= next_beat.unused;
			end
		end
	end

	// receive beats from the mac
	assign rx_load = !rx_valid_o || rx_ready_i;
	assign lane.rx_frame_ready = rx_load;
	assign rx_da = da_of(lane.rx_frame_data, 1'b0);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_data_o <= '0;
			rx_first_o <= 1'b0;
			rx_last_o <= 1'b0;
			rx_unused_o <= '0;
			rx_valid_o <= 1'b0;
		end else if (rx_load) begin
			rx_valid_o <= lane.rx_frame_valid;
			if (lane.rx_frame_valid) begin
				rx_data_o <= lane.rx_frame_data;
				rx_first_o <= lane.rx_frame_first;
				rx_last_o <= lane.rx_frame_last;
				rx_unused_o <= lane.rx_frame_unused;
			end
		end
	end

	// address flags of each received frame
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_multicast_o <= 1'b0;
			rx_local_o <= 1'b0;
		end else if (rx_load && lane.rx_frame_valid && lane.rx_frame_first) begin
			rx_multicast_o <= rx_da[DA_MCAST_BIT];
			rx_local_o <= rx_da[DA_LOCAL_BIT];
		end
	end
endmodule // client_lane_end
`default_nettype wire

// File: design/frame_lane_if.sv
`timescale 1ns/1ps
`default_nettype none
interface frame_lane_if;
	import frame_lane_pkg::*;
	logic [BUS_W-1:0] tx_client_data_bus;
	logic tx_client_first_beat;
	logic tx_client_last_beat;
	logic [UNUSED_W-1:0] tx_client_unused_byte_count;
	logic tx_client_valid;
	logic tx_client_ready;
	logic [BUS_W-1:0] rx_frame_data;
	logic rx_frame_first;
	logic rx_frame_last;
	logic [UNUSED_W-1:0] rx_frame_unused;
	logic rx_frame_valid;
	logic rx_frame_ready;

	modport client (
		output tx_client_data_bus, tx_client_first_beat, tx_client_last_beat,
		output tx_client_unused_byte_count, tx_client_valid,
		input tx_client_ready,
		input rx_frame_data, rx_frame_first, rx_frame_last, rx_frame_unused, rx_frame_valid,
		output rx_frame_ready
	);

	modport mac (
		input tx_client_data_bus, tx_client_first_beat, tx_client_last_beat,
		input tx_client_unused_byte_count, tx_client_valid,
		output tx_client_ready,
		output rx_frame_data, rx_frame_first, rx_frame_last, rx_frame_unused, rx_frame_valid,
		input rx_frame_ready
	);
endinterface
`default_nettype wire

// File: design/frame_lane_pkg.sv
package frame_lane_pkg;
	localparam int BUS_W = 256;
	localparam int BUS_BYTES = 32;
	localparam int UNUSED_W = 5;
	localparam int OCTET_W = 8;
	localparam int HDR_BYTES_PLAIN = 14;
	localparam int HDR_BYTES_PT = 22;
	localparam int PRE_BYTES = 8;
	localparam int ADDR_W = 48;
	localparam int TL_W = 16;
	localparam int PRE_W = 64;
	localparam int START_MSB = 199;
	localparam int SFD_MSB = 255;
	localparam int DA_MCAST_BIT = 40;
	localparam int DA_LOCAL_BIT = 41;
	localparam int MIN_FRAME_BYTES = 64;
	localparam int MAX_PAD_BYTES = 46;
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0] START_OCTET = 8'hfb;
	localparam logic [7:0] SFD_OCTET = 8'hd5;

	typedef struct packed {
		logic [BUS_W-1:0] data;
		logic first;
		logic last;
		logic [UNUSED_W-1:0] unused;
	} beat_t;

	localparam int BEAT_W = $bits(beat_t);

	// destination address of a first beat, earliest octet in the top lane
	function automatic logic [ADDR_W-1:0] da_of(input logic [BUS_W-1:0] data, input logic pt);
		da_of = pt ? data[BUS_W-1-PRE_W -: ADDR_W] : data[BUS_W-1 -: ADDR_W];
	endfunction

	// bytes in a beat from its unused lane count
	function automatic logic [6:0] used_bytes(input logic [UNUSED_W-1:0] unused);
		used_bytes = 7'(BUS_BYTES) - {2'b00, unused};
	endfunction
endpackage

// File: design/mac_lane_end.sv
`timescale 1ns/1ps
`default_nettype none
module beat_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic push;
	logic pop;

	assign in_ready_o = count != (PW+1)'(DEPTH);
	assign out_valid_o = count != '0;
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= PW'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= PW'(rd_ptr + 1'b1);
			end
			count <= (PW+1)'(count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
		end
	end
endmodule // beat_fifo

module mac_lane_end
	import frame_lane_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	frame_lane_if.mac lane,
	input wire logic passthrough_i,
	output logic [BUS_W-1:0] phy_tx_data_o,
	output logic phy_tx_first_o,
	output logic phy_tx_last_o,
	output logic [UNUSED_W-1:0] phy_tx_unused_o,
	output logic phy_tx_valid_o,
	input wire logic phy_tx_ready_i,
	output logic [ADDR_W-1:0] tx_da_o,
	output logic tx_multicast_o,
	output logic tx_local_o,
	output logic tx_preamble_bad_o,
	input wire logic [BUS_W-1:0] phy_rx_data_i,
	input wire logic phy_rx_first_i,
	input wire logic phy_rx_last_i,
	input wire logic [UNUSED_W-1:0] phy_rx_unused_i,
	input wire logic phy_rx_valid_i,
	output logic phy_rx_ready_o,
	output logic rx_multicast_o,
	output logic rx_local_o,
	output logic rx_short_o
);
	beat_t in_beat;
	beat_t head;
	logic head_valid;
	logic head_ready;
	logic [ADDR_W-1:0] head_da;
	logic rx_take;
	logic next_rx_valid;
	logic [15:0] rx_count;
	logic [15:0] rx_total;
	logic [ADDR_W-1:0] rx_da;

	assign in_beat = '{data: lane.tx_client_data_bus, first: lane.tx_client_first_beat,
		last: lane.tx_client_last_beat, unused: lane.tx_client_unused_byte_count};

	beat_fifo #(.WIDTH(BEAT_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.in_data_i(in_beat),
		.in_valid_i(lane.tx_client_valid),
		.in_ready_o(lane.tx_client_ready),
		.out_data_o(head),
		.out_valid_o(head_valid),
		.out_ready_i(head_ready)
	);

	assign head_ready = !phy_tx_valid_o || phy_tx_ready_i;
	assign head_da = da_of(head.data, passthrough_i);

	// transmit beats to the line side, top lane earliest
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phy_tx_data_o <= '0;
			phy_tx_first_o <= 1'b0;
			phy_tx_last_o <= 1'b0;
			phy_tx_unused_o <= '0;
			phy_tx_valid_o <= 1'b0;
		end else if (head_ready) begin
			phy_tx_valid_o <= head_valid;
			if (head_valid) begin
				phy_tx_data_o <= head.data;
				phy_tx_first_o <= head.first;
				phy_tx_last_o <= head.last;
				phy_tx_unused_o <= head.unused;
			end
		end
	end

	// address flags and preamble check of each first beat
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_da_o <= '0;
			tx_multicast_o <= 1'b0;
			tx_local_o <= 1'b0;
			tx_preamble_bad_o <= 1'b0;
		end else if (head_ready && head_valid && head.first) begin
			tx_da_o <= head_da;
			tx_multicast_o <= head_da[DA_MCAST_BIT];
			tx_local_o <= head_da[DA_LOCAL_BIT];
			tx_preamble_bad_o <= passthrough_i &&
				(head.data[START_MSB -: OCTET_W] != START_OCTET ||
				head.data[SFD_MSB -: OCTET_W] != SFD_OCTET);
		end
	end

	// receive frames from the line side toward the client
	assign rx_take = phy_rx_valid_i && phy_rx_ready_o;
	assign next_rx_valid = rx_take || (lane.rx_frame_valid && !lane.rx_frame_ready);
	assign rx_da = da_of(phy_rx_data_i, 1'b0);
	assign rx_total = 16'(rx_count + {9'b0, used_bytes(phy_rx_unused_i)});

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lane.rx_frame_data <= '0;
			lane.rx_frame_first <= 1'b0;
			lane.rx_frame_last <= 1'b0;
			lane.rx_frame_unused <= '0;
			lane.rx_frame_valid <= 1'b0;
			phy_rx_ready_o <= 1'b0;
		end else begin
			lane.rx_frame_valid <= next_rx_valid;
			phy_rx_ready_o <= !next_rx_valid;
			if (rx_take) begin
				lane.rx_frame_data <= phy_rx_data_i;
				lane.rx_frame_first <= phy_rx_first_i;
				lane.rx_frame_last <= phy_rx_last_i;
				lane.rx_frame_unused <= phy_rx_last_i ? phy_rx_unused_i : '0;
			end
		end
	end

	// frame length and address flags of received frames
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_count <= '0;
			rx_multicast_o <= 1'b0;
			rx_local_o <= 1'b0;
			rx_short_o <= 1'b0;
		end else if (rx_take) begin
			if (phy_rx_first_i) begin
				rx_multicast_o <= rx_da[DA_MCAST_BIT];
				rx_local_o <= rx_da[DA_LOCAL_BIT];
			end
			if (phy_rx_last_i) begin
				rx_count <= '0;
				rx_short_o <= phy_rx_first_i ?
					used_bytes(phy_rx_unused_i) < 7'(MIN_FRAME_BYTES) :
					rx_total < 16'(MIN_FRAME_BYTES);
			end else begin
				rx_count <= phy_rx_first_i ? 16'(BUS_BYTES) : 16'(rx_count + 16'(BUS_BYTES));
			end
		end
	end
endmodule // mac_lane_end
`default_nettype wire

// File: verification/lane_order_props.sv
`timescale 1ns/1ps
`default_nettype none
module lane_order_props
	import frame_lane_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic passthrough_i,
	input wire logic [BUS_W-1:0] tx_client_data_bus,
	input wire logic tx_client_first_beat,
	input wire logic tx_client_last_beat,
	input wire logic [UNUSED_W-1:0] tx_client_unused_byte_count,
	input wire logic tx_client_valid,
	input wire logic tx_client_ready,
	input wire logic [BUS_W-1:0] rx_frame_data,
	input wire logic rx_frame_first,
	input wire logic rx_frame_last,
	input wire logic [UNUSED_W-1:0] rx_frame_unused,
	input wire logic rx_frame_valid,
	input wire logic rx_frame_ready
);
	logic tx_open;
	logic rx_open;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// frame in progress on each direction
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_open <= 1'b0;
			rx_open <= 1'b0;
		end else begin
			if (tx_client_valid && tx_client_ready) tx_open <= !tx_client_last_beat;
			if (rx_frame_valid && rx_frame_ready) rx_open <= !rx_frame_last;
		end
	end
	tx_hold_a: assert property (
		tx_client_valid && !tx_client_ready |=> tx_client_valid && $stable(tx_client_data_bus))
		else $error("tx beat changed while stalled");
	tx_lanes_a: assert property (
		tx_client_valid && !tx_client_last_beat |-> tx_client_unused_byte_count == 5'h00)
		else $error("tx unused lanes on inner beat");
	tx_sop_a: assert property (tx_client_valid && !tx_open |-> tx_client_first_beat)
		else $error("tx frame lacks first mark");
	tx_mid_a: assert property (tx_client_valid && tx_open |-> !tx_client_first_beat)
		else $error("tx first mark inside frame");
	plain_fill_a: assert property (
		tx_client_valid && tx_client_first_beat && tx_client_last_beat && !passthrough_i
		|-> tx_client_unused_byte_count <= 5'h11) else $error("plain header too short");
	pt_fill_a: assert property (
		tx_client_valid && tx_client_first_beat && tx_client_last_beat && passthrough_i
		|-> tx_client_unused_byte_count <= 5'h09) else $error("preamble header too short");
	rx_hold_a: assert property (
		rx_frame_valid && !rx_frame_ready |-> ##1 rx_frame_valid && $stable(rx_frame_data))
		else $error("rx beat changed while stalled");
	rx_lanes_a: assert property (
		rx_frame_valid && !rx_frame_last |-> rx_frame_unused == 5'h00)
		else $error("rx unused lanes on inner beat");
	rx_sop_a: assert property (rx_frame_valid && !rx_open |-> rx_frame_first)
		else $error("rx frame lacks first mark");
endmodule // lane_order_props
`default_nettype wire

// File: verification/test_client_frame_lane_order.sv
`timescale 1ns/1ps
`default_nettype none
module test_client_frame_lane_order;
	import frame_lane_pkg::*;
	typedef struct {logic [BUS_W-1:0] d; logic f; logic l; logic [4:0] u; logic [47:0] da;
		logic bad;} exp_t;
	exp_t txq[$];
	exp_t rxq[$];
	exp_t te;
	exp_t re;
	integer seed = 32'h6d58;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	logic clk_i = 0;
	logic resetn_i = 0;
	logic pt = 0, hv = 0, pv = 0, pl = 1, rxr = 0, ptr = 0, hold = 1, rf = 0, rl = 0, rv = 0;
	logic [PRE_W-1:0] pre = '0;
	logic [ADDR_W-1:0] da = '0, sa = '0, tda;
	logic [TL_W-1:0] tl = '0;
	logic [BUS_W-1:0] pd = '0, rd = '0, c_d, p_d;
	logic [UNUSED_W-1:0] pu = '0, ru = '0, c_u, p_u;
	logic hr, pr, c_f, c_l, c_v, c_m, c_lo, p_f, p_l, p_v, tm, tlo, tbad, prr, m_m, m_lo, m_s;
	frame_lane_if lane();
	client_lane_end client_lane_end_inst (.clk_i(clk_i), .resetn_i(resetn_i), .lane(lane),
		.passthrough_i(pt), .preamble_i(pre), .da_i(da), .sa_i(sa), .tl_i(tl),
		.hdr_valid_i(hv), .hdr_ready_o(hr), .pay_data_i(pd), .pay_last_i(pl),
		.pay_unused_i(pu), .pay_valid_i(pv), .pay_ready_o(pr), .rx_data_o(c_d),
		.rx_first_o(c_f), .rx_last_o(c_l), .rx_unused_o(c_u), .rx_valid_o(c_v),
		.rx_ready_i(rxr), .rx_multicast_o(c_m), .rx_local_o(c_lo));
	mac_lane_end mac_lane_end_inst (.clk_i(clk_i), .resetn_i(resetn_i), .lane(lane),
		.passthrough_i(pt), .phy_tx_data_o(p_d), .phy_tx_first_o(p_f), .phy_tx_last_o(p_l),
		.phy_tx_unused_o(p_u), .phy_tx_valid_o(p_v), .phy_tx_ready_i(ptr), .tx_da_o(tda),
		.tx_multicast_o(tm), .tx_local_o(tlo), .tx_preamble_bad_o(tbad),
		.phy_rx_data_i(rd), .phy_rx_first_i(rf), .phy_rx_last_i(rl), .phy_rx_unused_i(ru),
		.phy_rx_valid_i(rv), .phy_rx_ready_o(prr), .rx_multicast_o(m_m), .rx_local_o(m_lo),
		.rx_short_o(m_s));
	lane_order_props lane_order_props_inst (.clk_i(clk_i), .resetn_i(resetn_i),
		.passthrough_i(pt), .tx_client_data_bus(lane.tx_client_data_bus),
		.tx_client_first_beat(lane.tx_client_first_beat),
		.tx_client_last_beat(lane.tx_client_last_beat),
		.tx_client_unused_byte_count(lane.tx_client_unused_byte_count),
		.tx_client_valid(lane.tx_client_valid), .tx_client_ready(lane.tx_client_ready),
		.rx_frame_data(lane.rx_frame_data), .rx_frame_first(lane.rx_frame_first),
		.rx_frame_last(lane.rx_frame_last), .rx_frame_unused(lane.rx_frame_unused),
		.rx_frame_valid(lane.rx_frame_valid), .rx_frame_ready(lane.rx_frame_ready));
	always #5 clk_i = ~clk_i;
	// far side stalls at random
	always @(negedge clk_i) begin
		rxr <= 1'($random(seed));
		ptr <= hold ? 1'b0 : 1'($random(seed));
	end
	function automatic logic [BUS_W-1:0] msk(input logic [4:0] u);
		msk = {BUS_W{1'b1}} << {u, 3'b000};
	endfunction
	task automatic chk(input string n, input logic [263:0] s, input logic [263:0] e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic rnd(output logic [BUS_W-1:0] v);
		for (int j = 0; j < 8; j++) v[j*32 +: 32] = $random(seed);
	endtask
	// raise, hold until ready seen at an edge, drop at next negedge
	task automatic hs(ref logic v, ref logic r);
		int n;
		n = 0;
		v = 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (!r && n < 3000);
		@(negedge clk_i);
		v = 1'b0;
	endtask
	// every fourth frame carries two payload words
	task automatic frame(input int k);
		logic [767:0] f;
		logic [BUS_W-1:0] h, w0, w1;
		logic [PRE_W-1:0] ph;
		logic [UNUSED_W-1:0] u0;
		int hb;
		int nw;
		int nb;
		int tot;
		exp_t e;
		hb = pt ? HDR_BYTES_PT : HDR_BYTES_PLAIN;
		nw = (k % 4 == 3) ? 2 : 1;
		rnd(h);
		rnd(w0);
		rnd(w1);
		u0 = 5'($random(seed));
		if (k < 2) u0 = 5'(hb - k); // exactly 32 and 33 bytes
		ph = {SFD_OCTET, h[159:112], START_OCTET};
		if (k % 3 == 0) ph = h[255:192];
		da = h[47:0];
		sa = h[95:48];
		tl = h[111:96];
		pre = ph;
		f = '0;
		if (pt) f[767 -: 176] = {ph, h[47:0], h[95:48], h[111:96]};
		else f[767 -: 112] = {h[47:0], h[95:48], h[111:96]};
		f[767-hb*8 -: BUS_W] = w0;
		if (nw == 2) f[511-hb*8 -: BUS_W] = w1;
		tot = hb + nw * BUS_BYTES - u0;
		nb = (tot + BUS_BYTES - 1) / BUS_BYTES;
		e.da = h[47:0];
		e.bad = pt && (ph[7:0] != START_OCTET || ph[63:56] != SFD_OCTET);
		for (int i = 0; i < nb; i++) begin
			e.d = f[767-i*BUS_W -: BUS_W];
			e.f = i == 0;
			e.l = i == nb - 1;
			e.u = e.l ? 5'(nb * BUS_BYTES - tot) : 5'h00;
			txq.push_back(e);
		end
		hs(hv, hr);
		pd = w0;
		pl = nw == 1;
		pu = u0;
		hs(pv, pr);
		if (nw == 2) begin
			@(negedge clk_i);
			pd = w1;
			pl = 1'b1;
			hs(pv, pr);
		end
	endtask
	task automatic rxf(input int nb, input logic [4:0] u);
		exp_t e;
		int n;
		for (int i = 0; i < nb; i++) begin
			rnd(rd);
			rf = i == 0;
			rl = i == nb - 1;
			ru = rl ? u : 5'h00;
			if (i == 0) e.da = rd[255 -: 48];
			e.d = rd;
			e.f = rf;
			e.l = rl;
			e.u = ru;
			rxq.push_back(e);
			hs(rv, prr);
			@(negedge clk_i);
		end
		for (n = 0; n < 3000 && rxq.size() != 0; n++) @(negedge clk_i);
		chk("rx flags", {m_s, m_lo, m_m, c_lo, c_m},
			{(nb * 32 - u) < MIN_FRAME_BYTES, e.da[41], e.da[40], e.da[41], e.da[40]});
	endtask
	always @(posedge clk_i) begin
		if (resetn_i && p_v && ptr) begin
			te = txq.pop_front();
			chk("tx data", p_d & msk(te.u), te.d & msk(te.u));
			chk("tx marks", {p_f, p_l, p_u}, {te.f, te.l, te.u});
			if (te.f) chk("tx addr", {tbad, tlo, tm, tda},
				{te.bad, te.da[41], te.da[40], te.da});
		end
		if (resetn_i && c_v && rxr) begin
			re = rxq.pop_front();
			chk("rx beat", {c_d & msk(re.u), c_f, c_l, c_u},
				{re.d & msk(re.u), re.f, re.l, re.u});
		end
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	initial begin
		repeat (8) @(posedge clk_i);
		@(negedge clk_i);
		resetn_i = 1'b1;
		repeat (2) @(negedge clk_i);
		for (int p = 0; p < 2; p++) begin
			pt = p[0];
			fork
				for (int k = 0; k < 24; k++) frame(k);
				begin
					for (int n = 0; n < 3000 && lane.tx_client_ready !== 1'b0; n++) @(negedge clk_i);
					chk("fifo full", lane.tx_client_ready, 1'b0);
					@(posedge clk_i);
					hold = 1'b0;
				end
			join
			for (int n = 0; n < 3000 && txq.size() != 0; n++) @(negedge clk_i);
			chk("tx drained", txq.size() == 0, 1'b1);
			@(posedge clk_i);
			hold = 1'b1;
			@(negedge clk_i);
		end
		rxf(1, 5'($random(seed)));
		rxf(2, 5'h00);
		rxf(2, 5'h01);
		for (int k = 0; k < 6; k++) rxf(1 + k % 3, 5'($random(seed)));
		finish_test();
	end
endmodule // test_client_frame_lane_order
`default_nettype wire
